// [shared/codec_serial_if_consts.vh]
// Register map, field positions and reset values of the codec serial interface.
`ifndef CODEC_SERIAL_IF_CONSTS_VH
`define CODEC_SERIAL_IF_CONSTS_VH

// ============================================================
// Register word indexes
`define CSI_REG_CONTROL_ONE  5'h00
`define CSI_REG_CONTROL_TWO  5'h01
`define CSI_REG_BIT_DIVIDER  5'h02
`define CSI_REG_STATUS       5'h03
`define CSI_REG_RX_SLOTS     5'h04
`define CSI_REG_TX_SLOTS     5'h05
`define CSI_REG_TX_BUF_BASE  5'h08
`define CSI_REG_RX_BUF_BASE  5'h0C

// ============================================================
// Writable bit masks and reset values
`define CSI_MASK_CONTROL_ONE 16'h87E3
`define CSI_MASK_CONTROL_TWO 16'h0DEF
`define CSI_MASK_BIT_DIVIDER 16'h0FFF
`define CSI_RESET_VALUE      16'h0000

// ============================================================
// Control one fields
`define CSI_BIT_ENABLE       15
`define CSI_BIT_CLOCK_DIR    10
`define CSI_BIT_CLOCK_EDGE   9
`define CSI_BIT_FS_DIR       8
`define CSI_BIT_UNF_REPEAT   7
`define CSI_BIT_IDLE_DRIVE   6
`define CSI_BIT_JUSTIFY      5
`define CSI_FRAME_MODE_HI    1
`define CSI_FRAME_MODE_LO    0

// ============================================================
// Control two fields
`define CSI_DEPTH_HI         11
`define CSI_DEPTH_LO         10
`define CSI_WORDS_HI         8
`define CSI_WORDS_LO         5
`define CSI_WSIZE_HI         3
`define CSI_WSIZE_LO         0

// ============================================================
// Status fields
`define CSI_SLOT_HI          11
`define CSI_SLOT_LO          8
`define CSI_BIT_RX_OVERFLOW  3
`define CSI_BIT_RX_FULL      2
`define CSI_BIT_TX_UNDERFLOW 1
`define CSI_BIT_TX_EMPTY     0

// ============================================================
// Frame modes and fixed slot lengths
`define CSI_MODE_MULTI       2'h0
`define CSI_MODE_I2S         2'h1
`define CSI_MODE_LINK16      2'h2
`define CSI_MODE_LINK20      2'h3
`define CSI_LINK16_BITS      5'h10
`define CSI_LINK20_BITS      5'h14
`define CSI_SHIFT_BITS       5'h10
`define CSI_EXT_POS_HOLD     9'h1FE

`endif

// [rtl/pin_synchroniser.v]
// Two-stage synchroniser with edge detection for link pins.
`timescale 1ns/10ps
`default_nettype none

module pin_synchroniser #(
    parameter WIDTH = 1
) (
    input  wire             CLK,    // System clock
    input  wire             RST_B,  // Synchronous reset, active low
    input  wire [WIDTH-1:0] PIN,    // Asynchronous pin levels
    output wire [WIDTH-1:0] LEVEL,  // Synchronised levels
    output wire [WIDTH-1:0] RISE,   // One-cycle pulse on a rising edge
    output wire [WIDTH-1:0] FALL    // One-cycle pulse on a falling edge
);

    reg [WIDTH-1:0] stage_one;
    reg [WIDTH-1:0] stage_two;
    reg [WIDTH-1:0] stage_old;

    // The first stage feeds only the second; edges come from later stages.
    always @(posedge CLK) begin
        if (!RST_B) begin
            stage_one <= {WIDTH{1'b0}};
            stage_two <= {WIDTH{1'b0}};
            stage_old <= {WIDTH{1'b0}};
        end else begin
            stage_one <= PIN;
            stage_two <= stage_one;
            stage_old <= stage_two;
        end
    end

    assign LEVEL = stage_two;
    assign RISE  = stage_two & ~stage_old;
    assign FALL  = ~stage_two & stage_old;

endmodule // pin_synchroniser

`default_nettype wire

// [rtl/codec_serial_if.v]
// Codec serial interface: registers, framing, slot control and buffers.
//
// Functional notes
// - Frame sync direction bit set makes frame sync an input, clear an output.
// - Underflow resends last written transmit value when repeat bit set, else zeros.
// - Disabled transmit slots tri-state output if idle drive set, else drive low.
// - Justify set starts data with sync bit; clear starts one bit later.
// - Frame mode: 11 AC-Link 20, 10 AC-Link 16, 01 I2S, 00 multi-channel.
// - Buffer depth field plus one words transfer between interrupts.
// - Frame words field plus one words form a frame.
// - Word size field plus one gives the word length in bits in multi-channel and I2S modes.
// - Twelve-bit divisor drives the bit clock generator; top four bits read zero.
// - Read-only slot field shows the currently active time slot.
// - Receive overflow flag sets when any receive word overflows.
// - Receive full flag reads one while receive registers hold new data.
// - Transmit underflow flag sets when any transmit word underflows.
// - Transmit empty flag reads one while transmit registers are empty.
// - Receive slot enable bits choose slots whose input data is captured.
// - Transmit slot enable bits choose slots that send buffer contents.
// - Unimplemented register bits read zero and ignore writes.
// - Sixteen-bit shift register moves data most significant bit first.
// - Buffer words left justified; short received words zero-filled low.
// - Clock edge bit set: change on falling, sample on rising; else reversed.
// - Bit clock direction set makes bit clock an input, clear an output.
`timescale 1ns/10ps
`default_nettype none
`include "codec_serial_if_consts.vh"

module codec_serial_if (
    input  wire        CLK,         // System clock, 20 MHz
    input  wire        RST_B,       // Synchronous reset, active low
    input  wire [4:0]  ADDR,        // Register word index
    input  wire [15:0] WDATA,       // Write data
    input  wire        WR,          // Write strobe
    input  wire        RD,          // Read strobe
    output wire [15:0] RDATA,       // Read data, valid the cycle after RD
    input  wire        SCK_IN,      // Bit clock pin input
    output wire        SCK_OUT,     // Bit clock pin output
    output wire        SCK_OE,      // Bit clock pin output enable
    input  wire        FS_IN,       // Frame sync pin input
    output wire        FS_OUT,      // Frame sync pin output
    output wire        FS_OE,       // Frame sync pin output enable
    input  wire        SDI,         // Serial data input pin
    output wire        SDO,         // Serial data output pin
    output wire        SDO_OE,      // Serial data output enable
    output wire        BLOCK_DONE   // Pulse when a buffer block completes
);

    // ============================================================
    // Register storage
    reg  [15:0] control_one;
    reg  [15:0] control_two;
    reg  [15:0] bit_divider;
    reg  [15:0] rx_slot_enable;
    reg  [15:0] tx_slot_enable;
    reg  [15:0] tx_buf [0:3];
    reg  [15:0] rx_buf [0:3];
    reg  [15:0] last_written;
    reg  [15:0] rdata;
    reg         rx_overflow;
    reg         rx_full;
    reg         tx_underflow;
    reg         tx_empty;

    wire        enable           = control_one[`CSI_BIT_ENABLE];
    wire        bit_clock_dir    = control_one[`CSI_BIT_CLOCK_DIR];
    wire        bit_clock_edge   = control_one[`CSI_BIT_CLOCK_EDGE];
    wire        frame_sync_dir   = control_one[`CSI_BIT_FS_DIR];
    wire        underflow_repeat = control_one[`CSI_BIT_UNF_REPEAT];
    wire        idle_slot_drive  = control_one[`CSI_BIT_IDLE_DRIVE];
    wire        data_justify     = control_one[`CSI_BIT_JUSTIFY];
    wire [1:0]  frame_mode =
        control_one[`CSI_FRAME_MODE_HI:`CSI_FRAME_MODE_LO];
    wire [1:0]  buffer_depth = control_two[`CSI_DEPTH_HI:`CSI_DEPTH_LO];
    wire [3:0]  frame_words  = control_two[`CSI_WORDS_HI:`CSI_WORDS_LO];
    wire [3:0]  word_size    = control_two[`CSI_WSIZE_HI:`CSI_WSIZE_LO];
    wire [11:0] bit_clock_divisor = bit_divider[11:0];

    // ============================================================
    // Link pin synchronisers
    wire [2:0]  pin_level;
    wire [2:0]  pin_rise;
    wire [2:0]  pin_fall;

    pin_synchroniser #(
        .WIDTH (3)
    ) link_sync (
        .CLK   (CLK),
        .RST_B (RST_B),
        .PIN   ({SDI, FS_IN, SCK_IN}),
        .LEVEL (pin_level),
        .RISE  (pin_rise),
        .FALL  (pin_fall)
    );

    // ============================================================
    // Bit clock generator and edge selection
    reg  [11:0] div_count;
    reg         sck_gen;
    wire        div_tick = enable && !bit_clock_dir &&
                           (div_count == bit_clock_divisor);

    // Half period is divisor plus one system clocks.
    always @(posedge CLK) begin
        if (!RST_B || !enable || bit_clock_dir) begin
            div_count <= 12'h000;
            sck_gen   <= 1'b0;
        end else if (div_tick) begin
            div_count <= 12'h000;
            sck_gen   <= ~sck_gen;
        end else begin
            div_count <= div_count + 12'h001;
        end
    end

    wire sck_rise = bit_clock_dir ? pin_rise[0] : (div_tick & ~sck_gen);
    wire sck_fall = bit_clock_dir ? pin_fall[0] : (div_tick & sck_gen);
    wire drive_edge  = enable && (bit_clock_edge ? sck_fall : sck_rise);
    wire sample_edge = enable && (bit_clock_edge ? sck_rise : sck_fall);

    // ============================================================
    // Frame geometry
    reg  [4:0]  slot_bits;
    always @* begin
        case (frame_mode)
            `CSI_MODE_LINK16: slot_bits = `CSI_LINK16_BITS;
            `CSI_MODE_LINK20: slot_bits = `CSI_LINK20_BITS;
            default:          slot_bits = {1'b0, word_size} + 5'h01;
        endcase
    end

    wire [4:0]  words_in_frame = {1'b0, frame_words} + 5'h01;
    wire [9:0]  frame_product  = {5'h00, words_in_frame} *
                                 {5'h00, slot_bits};
    wire [8:0]  frame_bits     = frame_product[8:0];
    wire [4:0]  used_bits = (slot_bits > `CSI_SHIFT_BITS) ?
                            `CSI_SHIFT_BITS : slot_bits;
    wire [4:0]  justify_shift = `CSI_SHIFT_BITS - used_bits;

    // ============================================================
    // Frame position, slot and bit counters
    reg  [8:0]  frame_pos;
    reg  [4:0]  bit_index;
    reg  [3:0]  slot;
    reg         active;
    reg  [1:0]  buf_ptr;
    reg  [15:0] tx_shift;
    reg  [15:0] rx_shift;
    reg         fs_gen;
    reg         fs_seen;
    reg         sdo;
    reg         sdo_oe;
    reg         block_done;

    wire        fs_external = frame_sync_dir;
    wire        fs_start = fs_external && sample_edge &&
                           ((frame_mode == `CSI_MODE_I2S) ?
                            (fs_seen & ~pin_level[1]) :
                            (~fs_seen & pin_level[1]));
    wire [8:0]  next_frame_pos =
        (!fs_external && frame_pos == frame_bits - 9'h001) ? 9'h000 :
        (fs_external && frame_pos == `CSI_EXT_POS_HOLD) ? frame_pos :
        frame_pos + 9'h001;
    // An outside sync is seen only at the sample edge of its own bit, so with
    // justify set the start is predicted from the previous sync instead.
    wire [8:0]  start_pos = !data_justify ? 9'h001 :
                            fs_external ? frame_bits : 9'h000;
    wire        data_restart = (next_frame_pos == start_pos);
    wire        last_bit = (bit_index == slot_bits - 5'h01);
    wire [4:0]  next_bit_index = (data_restart || last_bit) ?
                                 5'h00 : bit_index + 5'h01;
    wire [3:0]  next_slot = data_restart ? 4'h0 :
                            (!last_bit) ? slot :
                            (slot == frame_words) ? 4'h0 : slot + 4'h1;
    wire        next_active = active | data_restart;
    wire        next_tx_on = next_active && tx_slot_enable[next_slot];

    // Word sent when a slot opens; an empty buffer counts as underflow.
    wire [15:0] load_word = !tx_empty ? tx_buf[buf_ptr] :
                            underflow_repeat ? last_written :
                            16'h0000;
    wire [15:0] next_tx_shift = (next_bit_index == 5'h00) ? load_word :
                                {tx_shift[14:0], 1'b0};
    wire        next_sdo = (next_bit_index < `CSI_SHIFT_BITS) &&
                           next_tx_shift[15];

    // Frame sync shape for the next bit clock period.
    reg         next_fs_gen;
    always @* begin
        case (frame_mode)
            `CSI_MODE_MULTI: next_fs_gen = (next_frame_pos == 9'h000);
            `CSI_MODE_I2S:   next_fs_gen =
                                 (next_frame_pos >= {4'h0, slot_bits});
            default:         next_fs_gen =
                                 (next_frame_pos < {4'h0,
                                                    `CSI_LINK16_BITS});
        endcase
    end

    wire        rx_on = active && rx_slot_enable[slot];
    wire        slot_used = active &&
                            (rx_slot_enable[slot] | tx_slot_enable[slot]);
    wire        word_end = sample_edge && last_bit && slot_used;
    wire        block_end = word_end && (buf_ptr == buffer_depth);
    wire [15:0] rx_word = {rx_shift[14:0], pin_level[2]} << justify_shift;

    wire        rx_buf_read = RD &&
                              (ADDR[4:2] == `CSI_REG_RX_BUF_BASE >> 2);
    wire        tx_buf_write = WR &&
                               (ADDR[4:2] == `CSI_REG_TX_BUF_BASE >> 2);
    wire        tx_underrun = drive_edge && next_tx_on &&
                              (next_bit_index == 5'h00) && tx_empty;

    always @(posedge CLK) begin
        if (!RST_B || !enable) begin
            frame_pos    <= `CSI_EXT_POS_HOLD;
            bit_index    <= 5'h00;
            slot         <= 4'h0;
            active       <= 1'b0;
            buf_ptr      <= 2'h0;
            tx_shift     <= 16'h0000;
            rx_shift     <= 16'h0000;
            fs_gen       <= 1'b0;
            fs_seen      <= 1'b0;
            sdo          <= 1'b0;
            sdo_oe       <= 1'b0;
            block_done   <= 1'b0;
            rx_overflow  <= 1'b0;
            tx_underflow <= 1'b0;
        end else begin
            block_done <= block_end;
            if (fs_start) begin
                frame_pos <= 9'h000;
            end else if (drive_edge) begin
                frame_pos <= next_frame_pos;
            end
            if (sample_edge) begin
                fs_seen <= pin_level[1];
            end
            if (drive_edge) begin
                bit_index <= next_bit_index;
                slot      <= next_slot;
                active    <= next_active;
                tx_shift  <= next_tx_shift;
                fs_gen    <= next_fs_gen;
                sdo       <= next_tx_on && next_sdo;
                sdo_oe    <= next_tx_on || !idle_slot_drive;
            end
            if (sample_edge && rx_on && bit_index < `CSI_SHIFT_BITS) begin
                rx_shift <= {rx_shift[14:0], pin_level[2]};
            end
            if (word_end) begin
                buf_ptr <= block_end ? 2'h0 : buf_ptr + 2'h1;
            end
            if (tx_underrun) begin
                tx_underflow <= 1'b1;
            end
            if (block_end && rx_full && !rx_buf_read) begin
                rx_overflow <= 1'b1;
            end
        end
    end

    // Receive words land left justified with zeros below.
    always @(posedge CLK) begin
        if (word_end && rx_on) begin
            rx_buf[buf_ptr] <= rx_word;
        end
    end

    // Hardware sets win over software clears in the same cycle.
    always @(posedge CLK) begin
        if (!RST_B) begin
            rx_full  <= 1'b0;
            tx_empty <= 1'b0;
        end else begin
            if (block_end) begin
                rx_full <= 1'b1;
            end else if (rx_buf_read) begin
                rx_full <= 1'b0;
            end
            if (block_end) begin
                tx_empty <= 1'b1;
            end else if (tx_buf_write) begin
                tx_empty <= 1'b0;
            end
        end
    end

    // ============================================================
    // Register writes
    always @(posedge CLK) begin
        if (!RST_B) begin
            control_one    <= `CSI_RESET_VALUE;
            control_two    <= `CSI_RESET_VALUE;
            bit_divider    <= `CSI_RESET_VALUE;
            rx_slot_enable <= `CSI_RESET_VALUE;
            tx_slot_enable <= `CSI_RESET_VALUE;
            last_written   <= `CSI_RESET_VALUE;
        end else if (WR) begin
            case (ADDR)
                `CSI_REG_CONTROL_ONE:
                    control_one <= WDATA & `CSI_MASK_CONTROL_ONE;
                `CSI_REG_CONTROL_TWO:
                    control_two <= WDATA & `CSI_MASK_CONTROL_TWO;
                `CSI_REG_BIT_DIVIDER:
                    bit_divider <= WDATA & `CSI_MASK_BIT_DIVIDER;
                `CSI_REG_RX_SLOTS: rx_slot_enable <= WDATA;
                `CSI_REG_TX_SLOTS: tx_slot_enable <= WDATA;
                default: begin
                    if (tx_buf_write) begin
                        last_written <= WDATA;
                    end
                end
            endcase
        end
    end

    always @(posedge CLK) begin
        if (tx_buf_write) begin
            tx_buf[ADDR[1:0]] <= WDATA;
        end
    end

    // ============================================================
    // Register reads
    reg  [15:0] read_value;
    always @* begin
        case (ADDR)
            `CSI_REG_CONTROL_ONE: read_value = control_one;
            `CSI_REG_CONTROL_TWO: read_value = control_two;
            `CSI_REG_BIT_DIVIDER: read_value = bit_divider;
            `CSI_REG_STATUS: read_value = {4'h0, slot, 4'h0,
                                           rx_overflow, rx_full,
                                           tx_underflow, tx_empty};
            `CSI_REG_RX_SLOTS: read_value = rx_slot_enable;
            `CSI_REG_TX_SLOTS: read_value = tx_slot_enable;
            default: begin
                if (ADDR[4:2] == `CSI_REG_TX_BUF_BASE >> 2) begin
                    read_value = tx_buf[ADDR[1:0]];
                end else if (ADDR[4:2] == `CSI_REG_RX_BUF_BASE >> 2) begin
                    read_value = rx_buf[ADDR[1:0]];
                end else begin
                    read_value = 16'h0000;
                end
            end
        endcase
    end

    // Read data stands for one cycle only, zero otherwise.
    always @(posedge CLK) begin
        if (!RST_B) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= RD ? read_value : 16'h0000;
        end
    end

    // ============================================================
    // Outputs
    assign RDATA      = rdata;
    assign SCK_OUT    = sck_gen;
    assign SCK_OE     = enable && !bit_clock_dir;
    assign FS_OUT     = fs_gen;
    assign FS_OE      = enable && !fs_external;
    assign SDO        = sdo;
    assign SDO_OE     = sdo_oe;
    assign BLOCK_DONE = block_done;

endmodule // codec_serial_if

`default_nettype wire

// [testbench/codec_serial_if_props.sv]
// Port checker for the codec serial interface.
`timescale 1ns/10ps
`default_nettype none
`include "codec_serial_if_consts.vh"

module codec_serial_if_props (
    input wire logic        CLK,        // System clock
    input wire logic        RST_B,      // Reset, active low
    input wire logic [4:0]  ADDR,       // Register index
    input wire logic [15:0] WDATA,      // Write data
    input wire logic        WR,         // Write strobe
    input wire logic        RD,         // Read strobe
    input wire logic [15:0] RDATA,      // Read data
    input wire logic        SCK_OE,     // Bit clock enable
    input wire logic        FS_OE,      // Frame sync enable
    input wire logic        SDO_OE,     // Data out enable
    input wire logic        BLOCK_DONE  // Block pulse
);
    // ========================================
    // Shadow of control one
    logic [15:0] ctrl1_q;
    always_ff @(posedge CLK) begin
        if (!RST_B)
            ctrl1_q <= 16'h0000;
        else if (WR && ADDR == `CSI_REG_CONTROL_ONE)
            ctrl1_q <= WDATA & `CSI_MASK_CONTROL_ONE;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // ========================================
    // Properties
    property p_sck_dir; SCK_OE == (ctrl1_q[15] && !ctrl1_q[10]); endproperty
    a_sck_dir: assert property (p_sck_dir) else $error("bad SCK_OE");
    property p_fs_dir; FS_OE == (ctrl1_q[15] && !ctrl1_q[8]); endproperty
    a_fs_dir: assert property (p_fs_dir) else $error("bad FS_OE");
    property p_off_quiet;
        (!ctrl1_q[15] && !$past(ctrl1_q[15])) |-> (!SDO_OE && !BLOCK_DONE);
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("busy off");
    property p_done_pulse; BLOCK_DONE |=> !BLOCK_DONE [*3]; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done");
    property p_ctrl1_rb;
        $past(RD && ADDR == `CSI_REG_CONTROL_ONE) |-> RDATA == $past(ctrl1_q);
    endproperty
    a_ctrl1_rb: assert property (p_ctrl1_rb) else $error("ctrl1 read");
    property p_ctrl2_mask; $past(RD && ADDR == `CSI_REG_CONTROL_TWO)
        |-> (RDATA & ~`CSI_MASK_CONTROL_TWO) == 16'h0000; endproperty
    a_ctrl2_mask: assert property (p_ctrl2_mask) else $error("ctrl2");
    property p_div_mask; $past(RD && ADDR == `CSI_REG_BIT_DIVIDER)
        |-> RDATA[15:12] == 4'h0; endproperty
    a_div_mask: assert property (p_div_mask) else $error("divider");
    property p_stat_mask; $past(RD && ADDR == `CSI_REG_STATUS)
        |-> (RDATA[15:12] == 4'h0 && RDATA[7:4] == 4'h0); endproperty
    a_stat_mask: assert property (p_stat_mask) else $error("status");
endmodule // codec_serial_if_props

bind codec_serial_if codec_serial_if_props u_props (.CLK(CLK), .RST_B(RST_B),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .SCK_OE(SCK_OE), .FS_OE(FS_OE), .SDO_OE(SDO_OE), .BLOCK_DONE(BLOCK_DONE));
`default_nettype wire

// [testbench/codec_partner.sv]
// Behavioural codec on the far side of the serial link.
`timescale 1ns/10ps
`default_nettype none

module codec_partner (
    input  wire logic        run,      // Frames run while high
    input  wire logic        sck,      // Bit clock on the wire
    input  wire logic        fs,       // Frame sync on the wire
    input  wire logic        sdo,      // Data from the device
    output var  logic        sck_drv,  // Bit clock made here
    output var  logic        fs_drv,   // Frame sync made here
    output var  logic        sdi,      // Data to the device
    output var  logic [15:0] heard     // Last whole word heard
);
    localparam logic [15:0] SEND = 16'h5A3C;
    logic [3:0]  idx = 4'h0;
    logic [15:0] sh = 16'h0000;
    int          cnt = 16;
    initial begin
        sck_drv = 1'b0;
        fs_drv = 1'b0;
        sdi = 1'b0;
        heard = 16'h0000;
    end
    // The clock parks low when stopped, so no stray edge reaches the device.
    always #200 if (run || sck_drv) sck_drv = ~sck_drv;
    // An idle data line keeps toggling so a stale bit is never mistaken.
    always #50 if (!run) sdi = ~sdi;
    always @(posedge sck_drv) begin
        fs_drv <= (idx == 4'h0);
        sdi <= SEND[4'hF - idx];
        idx <= idx + 4'h1;
    end
    always @(negedge sck) begin
        if (fs) begin
            cnt = 1;
            sh = {15'h0000, sdo};
        end else if (cnt < 16) begin
            sh = {sh[14:0], sdo};
            cnt++;
            if (cnt == 16)
                heard = sh;
        end
    end
endmodule // codec_partner
`default_nettype wire

// [testbench/codec_serial_if_tb_top.sv]
// Self-checking bench of the codec serial interface.
`timescale 1ns/10ps
`default_nettype none
`include "codec_serial_if_consts.vh"

module codec_serial_if_tb_top;
    localparam logic [36:0] ROWS [7] = '{{5'h00, 16'h7FFF, 16'h07E3},
        {5'h01, 16'hFFFF, 16'h0DEF}, {5'h02, 16'hFFFF, 16'h0FFF},
        {5'h03, 16'hFFFF, 16'h0000}, {5'h04, 16'hFFFF, 16'hFFFF},
        {5'h05, 16'hFFFF, 16'hFFFF}, {5'h06, 16'hFFFF, 16'h0000}};
    logic        CLK;
    logic        RST_B = 1'b0;
    logic [4:0]  ADDR = 5'h00;
    logic [15:0] WDATA = 16'h0000;
    logic        WR = 1'b0;
    logic        RD = 1'b0;
    logic        run = 1'b0;
    wire  [15:0] RDATA, heard;
    wire         SCK_OUT, SCK_OE, FS_OUT, FS_OE, SDO, SDO_OE, BLOCK_DONE;
    wire         ext_sck, ext_fs, sdi;
    wire         sck_w = SCK_OE ? SCK_OUT : ext_sck;
    wire         fs_w = FS_OE ? FS_OUT : ext_fs;
    int          error_cnt = 0;
    int          checks = 0;

    codec_serial_if uut (.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .SCK_IN(sck_w), .SCK_OUT(SCK_OUT),
        .SCK_OE(SCK_OE), .FS_IN(fs_w), .FS_OUT(FS_OUT), .FS_OE(FS_OE),
        .SDI(sdi), .SDO(SDO), .SDO_OE(SDO_OE), .BLOCK_DONE(BLOCK_DONE));
    codec_partner peer (.run(run), .sck(sck_w), .fs(fs_w), .sdo(SDO),
        .sck_drv(ext_sck), .fs_drv(ext_fs), .sdi(sdi), .heard(heard));

    // ========================================
    // Tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 check(RDATA, exp);
    endtask
    task automatic reset_dut;
        @(posedge CLK);
        RST_B <= 1'b0;
        repeat (8) @(posedge CLK);
        RST_B <= 1'b1;
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            @(posedge CLK);
            #1 n++;
        end while (BLOCK_DONE !== 1'b1 && n < 3000);
        if (n >= 3000)
            error_cnt++;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ========================================
    // Stimulus
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end
    initial begin
        #2000000 error_cnt++;
        give_verdict();
    end
    initial begin
        reset_dut();
        for (int i = 0; i < 7; i++) begin
            rd_chk(ROWS[i][36:32], 16'h0000);
            wr(ROWS[i][36:32], ROWS[i][31:16]);
            rd_chk(ROWS[i][36:32], ROWS[i][15:0]);
        end
        for (int m = 0; m < 4; m++) begin
            wr(`CSI_REG_CONTROL_ONE, 16'(m));
            rd_chk(`CSI_REG_CONTROL_ONE, 16'(m));
        end
        reset_dut();
        rd_chk(`CSI_REG_CONTROL_TWO, 16'h0000);
        $display("registers and reset done");
        wr(`CSI_REG_BIT_DIVIDER, 16'h0001);
        wr(`CSI_REG_CONTROL_TWO, 16'h000F);
        wr(`CSI_REG_TX_SLOTS, 16'h0001);
        wr(`CSI_REG_RX_SLOTS, 16'h0001);
        wr(`CSI_REG_TX_BUF_BASE, 16'hA5C3);
        wr(`CSI_REG_CONTROL_ONE, 16'h8020);
        wait_done();
        repeat (8) @(posedge CLK);
        check(heard, 16'hA5C3);
        wait_done();
        repeat (8) @(posedge CLK);
        check(heard, 16'h0000);
        rd_chk(`CSI_REG_STATUS, 16'h000F);
        wr(`CSI_REG_CONTROL_ONE, 16'h0000);
        rd_chk(`CSI_REG_STATUS, 16'h0005);
        $display("internal clock transmit done");
        reset_dut();
        wr(`CSI_REG_CONTROL_TWO, 16'h000F);
        wr(`CSI_REG_RX_SLOTS, 16'h0001);
        wr(`CSI_REG_CONTROL_ONE, 16'h8520);
        run <= 1'b1;
        wait_done();
        rd_chk(`CSI_REG_RX_BUF_BASE, 16'h5A3C);
        rd_chk(`CSI_REG_STATUS, 16'h0001);
        check({14'h0, SDO_OE, SDO}, 16'h0002);
        check({14'h0, SCK_OE, FS_OE}, 16'h0000);
        wr(`CSI_REG_CONTROL_ONE, 16'h8560);
        repeat (40) @(posedge CLK);
        check({15'h0, SDO_OE}, 16'h0000);
        run <= 1'b0;
        $display("external clock receive done");
        give_verdict();
    end
endmodule // codec_serial_if_tb_top
`default_nettype wire
